// File: pat_pkg.sv
// Purpose: constants and types for the paged address translation unit
// Assumes: 16-bit virtual words, 1 K-word pages
// Notes: shared by the translation core only
package pat_pkg;
	localparam int VA_W = 16;
	localparam int OFS_W = 10;
	localparam int VPN_W = 6;
	localparam int PA_N_W = 19;
	localparam int PA_X_W = 24;
	localparam int PPN_W = 14;
	localparam int TBL_N = 4;
	localparam int ENT_N = 64;
	localparam logic [1:0] RING_RST = 2'h0;
	localparam logic [2:0] PERM_RST = 3'h0;
	localparam logic [13:0] PPN_RST = 14'h0000;
	localparam logic [23:0] PA_RST = 24'h00_0000;
	typedef enum logic [1:0] {
		PAT_FETCH = 2'h0,
		PAT_READ = 2'h1,
		PAT_WRITE = 2'h2
	} pat_acc_t;
	typedef enum logic [1:0] {
		PAT_IDLE = 2'h0,
		PAT_DONE = 2'h1,
		PAT_FAULT = 2'h3
	} pat_state_t;
endpackage

// File: pat_mmu.sv
// Purpose: page mapping and page/ring protection for a 16-bit core
// Assumes: inputs synchronous to clk; tables loaded over a plain write port
// Notes: one cycle from request to result
// Behaviour
// RULE1 - normal mode yields 19-bit physical address
// RULE2 - extended mode yields 24-bit physical address
// RULE3 - 1 K-word pages, page part replaced
// RULE4 - four page tables in fast registers
// RULE5 - every program sees 64 K-word space
// RULE6 - per-page read, write, fetch denial
// RULE7 - pages and programs on four rings
// RULE8 - block access when program ring lower
// RULE9 - low ten bits pass, six select
// RULE10 - failed check suppresses access, flags violation
`timescale 1ns/1ps
module pat_mmu (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic req,
	input wire logic [15:0] vaddr,
	input wire logic [1:0] acc,
	input wire logic [1:0] tbl_sel,
	input wire logic [1:0] prog_ring,
	input wire logic ext_mode,
	input wire logic ld,
	input wire logic [1:0] ld_tbl,
	input wire logic [5:0] ld_idx,
	input wire logic [13:0] ld_ppn,
	input wire logic [2:0] ld_deny,
	input wire logic [1:0] ld_ring,
	output logic mem_req,
	output logic [23:0] paddr,
	output logic violation,
	output logic done
);
	// RULE4 four tables, registers
	// storage: page number, deny bits (fetch,read,write), ring
	logic [13:0] ppn_tab [0:pat_pkg::TBL_N*pat_pkg::ENT_N-1];
	logic [2:0] deny_tab [0:pat_pkg::TBL_N*pat_pkg::ENT_N-1];
	logic [1:0] ring_tab [0:pat_pkg::TBL_N*pat_pkg::ENT_N-1];
	pat_pkg::pat_state_t state, next_state;
	logic next_mem_req, next_violation, next_done;
	logic [23:0] next_paddr;
	logic [7:0] sel; // table and entry index
	logic [13:0] e_ppn;
	logic [2:0] e_deny;
	logic [1:0] e_ring;
	logic denied;

	// flat index of table/entry
	function automatic logic [7:0] idx(input logic [1:0] t, input logic [5:0] e);
		idx = {t, e};
	endfunction

	// table loading; registers so lookup adds no extra cycle
	always_ff @(posedge clk) begin
		if (ld) begin
			ppn_tab[idx(ld_tbl, ld_idx)] <= ld_ppn;
			deny_tab[idx(ld_tbl, ld_idx)] <= ld_deny;
			ring_tab[idx(ld_tbl, ld_idx)] <= ld_ring;
		end
	end

	// lookup and checks
	always_comb begin
		// RULE9 upper six bits pick entry
		sel = idx(tbl_sel, vaddr[15:10]);
		e_ppn = ppn_tab[sel];
		e_deny = deny_tab[sel];
		e_ring = ring_tab[sel];
		denied = 1'b0;
		// RULE6 deny by access type
		case (acc)
			pat_pkg::PAT_FETCH: denied = e_deny[2];
			pat_pkg::PAT_READ: denied = e_deny[1];
			pat_pkg::PAT_WRITE: denied = e_deny[0];
			default: denied = 1'b1; // undefined type refused
		endcase
		// RULE8 RULE7 ring compare
		if (prog_ring < e_ring) begin
			denied = 1'b1;
		end
	end

	// next result values
	always_comb begin
		next_state = pat_pkg::PAT_IDLE;
		next_mem_req = 1'b0;
		next_violation = 1'b0;
		next_done = 1'b0;
		next_paddr = paddr; // hold last address
		if (!rst_b) begin
			next_paddr = pat_pkg::PA_RST;
		end else if (req) begin
			next_done = 1'b1;
			// RULE10 suppress and flag
			if (denied) begin
				next_state = pat_pkg::PAT_FAULT;
				next_violation = 1'b1;
			end else begin
				next_state = pat_pkg::PAT_DONE;
				next_mem_req = 1'b1;
				// RULE3 RULE5 RULE9 replace page part only
				if (ext_mode) begin
					// RULE2 full 14-bit page number
					next_paddr = {e_ppn, vaddr[9:0]};
				end else begin
					// RULE1 nine-bit page number
					next_paddr = {5'h00, e_ppn[8:0], vaddr[9:0]};
				end
			end
		end
	end

	// result registers
	always_ff @(posedge clk) begin
		state <= next_state;
		mem_req <= next_mem_req;
		violation <= next_violation;
		done <= next_done;
		paddr <= next_paddr;
	end

	// protection and result checks, all on the one clock

	// RULE10 access and fault exclusive
	property p_excl;
		@(posedge clk) disable iff (!rst_b) !(mem_req && violation);
	endproperty
	a_excl: assert property (p_excl) else $error("access and violation together"); // RULE10

	// RULE10 one outcome per result
	property p_one;
		@(posedge clk) disable iff (!rst_b) done == (mem_req ^ violation);
	endproperty
	a_one: assert property (p_one) else $error("result without single outcome"); // RULE10

	// RULE10 state follows outcome
	property p_state;
		@(posedge clk) disable iff (!rst_b)
			(state == pat_pkg::PAT_FAULT) == violation && (state == pat_pkg::PAT_DONE) == mem_req;
	endproperty
	a_state: assert property (p_state) else $error("state and outcome disagree"); // RULE10

	// RULE8 lower ring blocked
	property p_ring;
		@(posedge clk) disable iff (!rst_b)
			req && prog_ring < e_ring |=> violation && !mem_req;
	endproperty
	a_ring: assert property (p_ring) else $error("ring breach not blocked"); // RULE8

	// RULE6 fetch denial honoured
	property p_deny_f;
		@(posedge clk) disable iff (!rst_b)
			req && acc == pat_pkg::PAT_FETCH && e_deny[2] |=> violation;
	endproperty
	a_deny_f: assert property (p_deny_f) else $error("fetch not refused"); // RULE6

	// RULE6 read denial honoured
	property p_deny_r;
		@(posedge clk) disable iff (!rst_b)
			req && acc == pat_pkg::PAT_READ && e_deny[1] |=> violation;
	endproperty
	a_deny_r: assert property (p_deny_r) else $error("read not refused"); // RULE6

	// RULE6 write denial honoured
	property p_deny_w;
		@(posedge clk) disable iff (!rst_b)
			req && acc == pat_pkg::PAT_WRITE && e_deny[0] |=> violation;
	endproperty
	a_deny_w: assert property (p_deny_w) else $error("write not refused"); // RULE6

	// RULE6 undefined type refused
	property p_acc3;
		@(posedge clk) disable iff (!rst_b)
			req && acc == 2'h3 |=> violation && !mem_req;
	endproperty
	a_acc3: assert property (p_acc3) else $error("undefined access not refused"); // RULE6

	// RULE9 offset passes through
	property p_ofs;
		@(posedge clk) disable iff (!rst_b)
			req && !denied |=> mem_req && paddr[9:0] == $past(vaddr[9:0]);
	endproperty
	a_ofs: assert property (p_ofs) else $error("offset altered"); // RULE9

	// RULE1 normal stays 19 bits
	property p_norm;
		@(posedge clk) disable iff (!rst_b)
			req && !denied && !ext_mode |=> paddr[23:19] == 5'h00;
	endproperty
	a_norm: assert property (p_norm) else $error("normal address too wide"); // RULE1

	// RULE2 extended uses whole page
	property p_ext;
		@(posedge clk) disable iff (!rst_b)
			req && !denied && ext_mode |=> paddr[23:10] == $past(e_ppn);
	endproperty
	a_ext: assert property (p_ext) else $error("extended page wrong"); // RULE2

	// RULE10 refused access keeps address
	property p_hold;
		@(posedge clk) disable iff (!rst_b)
			req && denied |=> paddr == $past(paddr);
	endproperty
	a_hold: assert property (p_hold) else $error("address moved on refusal"); // RULE10

	// RULE4 answer next cycle
	property p_done;
		@(posedge clk) disable iff (!rst_b) req |=> done;
	endproperty
	a_done: assert property (p_done) else $error("no result after request"); // RULE4

	// RULE3 no access unasked
	property p_idle;
		@(posedge clk) disable iff (!rst_b) !req |=> !mem_req && !violation;
	endproperty
	a_idle: assert property (p_idle) else $error("spurious access"); // RULE3

	// RULE10 reset suppresses access
	property p_rst;
		@(posedge clk) !rst_b |=>
			!done && !mem_req && !violation && paddr == pat_pkg::PA_RST;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs active in reset"); // RULE10

	// main scenarios: wide access, ring refusal, fault then access, equal ring, restart
	c_ok: cover property (@(posedge clk) disable iff (!rst_b) mem_req && paddr[23]);
	c_ring: cover property (@(posedge clk) disable iff (!rst_b) req && prog_ring < e_ring);
	c_fault: cover property (@(posedge clk) disable iff (!rst_b) violation ##1 mem_req);
	c_eq: cover property (@(posedge clk) disable iff (!rst_b) req && !denied && prog_ring == e_ring ##1 mem_req);
	c_rst: cover property (@(posedge clk) !rst_b ##1 rst_b && req ##1 done);
endmodule

// File: pat_core.sv
// Purpose: core-side model issuing virtual accesses
// Assumes: signals change 1 ns after a rising edge
// Notes: req stays high between calls, so accesses run back to back
`timescale 1ns/1ps
module pat_core (
	input wire logic clk,
	output logic req,
	output logic [15:0] vaddr,
	output logic [1:0] acc,
	output logic [1:0] tbl_sel,
	output logic [1:0] prog_ring,
	output logic ext_mode
);
	// idle values at time zero
	initial begin
		{req, vaddr, acc, tbl_sel, prog_ring, ext_mode} = '0;
	end
	// one access, held across exactly one edge
	task automatic put(input logic [15:0] va, input logic [1:0] a, t, r, input logic x);
		req = 1'b1;
		{vaddr, acc, tbl_sel, prog_ring, ext_mode} = {va, a, t, r, x};
		@(posedge clk);
		#1;
	endtask
endmodule

// File: paged_address_translation_tb.sv
// Purpose: random self-checking bench for the translation unit
// Assumes: entries loaded before use; results one cycle after request
// Notes: shadow tables in the bench give the expected outcome
`timescale 1ns/1ps
module paged_address_translation_tb;
	logic clk, rst_b, ld, req, ext_mode, mem_req, violation, done, x;
	logic [1:0] ld_tbl, ld_ring, acc, tbl_sel, prog_ring, a, t, r;
	logic [5:0] ld_idx;
	logic [13:0] ld_ppn;
	logic [2:0] ld_deny;
	logic [15:0] vaddr, va;
	logic [23:0] paddr, exp_pa;
	logic [24:0] e;
	logic [13:0] ppn_m [4][64];
	logic [2:0] den_m [4][64];
	logic [1:0] rng_m [4][64];
	int n_errors = 0, total_checks = 0, cyc = 0, i;
	pat_core u_core (.clk(clk), .req(req), .vaddr(vaddr), .acc(acc), .tbl_sel(tbl_sel),
		.prog_ring(prog_ring), .ext_mode(ext_mode));
	pat_mmu u_dut (.clk(clk), .rst_b(rst_b), .req(req), .vaddr(vaddr), .acc(acc),
		.tbl_sel(tbl_sel), .prog_ring(prog_ring), .ext_mode(ext_mode), .ld(ld),
		.ld_tbl(ld_tbl), .ld_idx(ld_idx), .ld_ppn(ld_ppn), .ld_deny(ld_deny),
		.ld_ring(ld_ring), .mem_req(mem_req), .paddr(paddr), .violation(violation),
		.done(done));
	// expected {allowed, address}; deny bits are {fetch,read,write}
	function automatic logic [24:0] exp_fn(input logic [15:0] v, input logic [1:0] c, s, g,
		input logic m);
		logic [13:0] p;
		logic ok;
		p = ppn_m[s][v[15:10]];
		ok = (c != 2'h3) && !den_m[s][v[15:10]][2 - c] && (g >= rng_m[s][v[15:10]]);
		return {ok, m ? {p, v[9:0]} : {5'h00, p[8:0], v[9:0]}};
	endfunction
	task automatic chk(input string nm, input logic [23:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard, far above the ~700 cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		{rst_b, ld, ld_tbl, ld_idx, ld_ppn, ld_deny, ld_ring} = '0;
		void'($urandom(32'h97d2));
		repeat (16) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk("paddr_rst", paddr, 24'h0000);
		// fill all four tables with random entries
		for (i = 0; i < 256; i++) begin
			{ld, ld_tbl, ld_idx} = {1'b1, i[7:0]};
			{ld_ppn, ld_deny, ld_ring} = 19'($urandom);
			{ppn_m[ld_tbl][ld_idx], den_m[ld_tbl][ld_idx], rng_m[ld_tbl][ld_idx]} =
				{ld_ppn, ld_deny, ld_ring};
			@(posedge clk);
			#1;
		end
		ld = 1'b0;
		exp_pa = 24'h0000;
		// back-to-back accesses; first four walk every access type
		for (i = 0; i < 400; i++) begin
			// mid-run reset: pulses clear, address back to zero, tables kept
			if (i == 200) begin
				rst_b = 1'b0;
				@(posedge clk);
				#1;
				rst_b = 1'b1;
				exp_pa = 24'h0000;
				chk("rst_out", 24'({done, mem_req, violation}), 24'h0000);
				chk("rst_paddr", paddr, exp_pa);
			end
			{va, a, t, r, x} = 23'($urandom);
			if (i < 4) a = i[1:0];
			// odd passes sit on the equal-ring boundary
			if (i[0]) r = rng_m[t][va[15:10]];
			e = exp_fn(va, a, t, r, x);
			u_core.put(va, a, t, r, x);
			if (e[24]) exp_pa = e[23:0];
			chk("done", 24'(done), 24'h0001);
			chk("mem_req", 24'(mem_req), 24'(e[24]));
			chk("violation", 24'(violation), 24'(!e[24]));
			chk("paddr", paddr, exp_pa);
		end
		summarize();
	end
endmodule
